// File: hw/mmft_pkg.sv
// shared constants and types for the multi-mode function timer
package mmft_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_PERIOD  = 8'h04;
    localparam logic [7:0] ADDR_ELAPSED = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0c;
    // status field positions
    localparam int ST_OUT_BIT  = 0;
    localparam int ST_TRIG_BIT = 1;
    localparam int ST_IN_BIT   = 2;
    // count width: 500 h in tenths = 18000000, fits 25 bits
    localparam int CNT_W = 25;
    // period limits in tenths of a second
    localparam logic [24:0] PERIOD_MIN = 25'h0000001;
    localparam logic [24:0] PERIOD_MAX = 25'h112a880;
    localparam logic [24:0] PERIOD_RST = 25'h0000001;
    // tick timing
    localparam int CLK_HZ     = 100000000;
    localparam int TICK_MS    = 100;
    localparam int TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // timer type encodings as stored in the control register
    typedef enum logic [2:0] {
        MMFT_OFF,
        MMFT_PULSE,
        MMFT_ON_DELAY,
        MMFT_ONE_SHOT,
        MMFT_MIN_ON
    } mmft_type_t;
endpackage

// File: hw/mmft_tick.sv
// tenth-of-a-second tick prescaler
`timescale 1ns/1ps
module mmft_tick #(
    parameter int DIV = mmft_pkg::TICK_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    output logic      tick
);
    import mmft_pkg::*;
    logic [31:0] cnt_ff;

    // free-running divider, one-cycle tick at wrap
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_ff <= 32'h0;
            tick   <= 1'b0;
        end else if (cnt_ff == 32'(DIV - 1)) begin
            cnt_ff <= 32'h0;
            tick   <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
            tick   <= 1'b0;
        end
    end
endmodule

// File: hw/mmft_top.sv
// multi-mode function timer with axi4-lite register slave
// Operation
// - five types: off, pulse, delay, shot, min-on
// - pulse: rising input starts output for period
// - pulse: re-trigger restarts timing from zero
// - pulse: flag equals output
// - on-delay: output on after period while input
// - on-delay: input off clears elapsed count
// - on-delay: flag equals input
// - shot: period write with input on starts
// - shot: input off forces output off, freezes
// - shot: flag set by write until off
// - shot: rewrite allowed, no self restart
// - min-on: output input plus one period
// - min-on: input return resets elapsed count
// - min-on: flag while elapsed above zero
// - period range tenth second to 500 hours
// - elapsed count readable
// - output state readable
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module mmft_top #(
    parameter int TICK_DIV = mmft_pkg::TICK_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        trig_in,
    output logic             timer_out,
    output logic             triggered,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import mmft_pkg::*;

    logic             tick;
    logic [2:0]       in_sync_ff;
    logic             in_ff;
    logic             in_prev_ff;
    mmft_type_t       type_ff;
    logic [CNT_W-1:0] period_ff;
    logic [CNT_W-1:0] elapsed_ff;
    logic [CNT_W-1:0] nxt_elapsed;
    logic             running_ff;
    logic             nxt_running;
    logic             nxt_out;
    logic             nxt_trig;
    logic             shot_flag_ff;
    logic             nxt_shot_flag;
    logic             period_wr;
    logic             aw_held_ff;
    logic             w_held_ff;
    logic [7:0]       awaddr_ff;
    logic [31:0]      wdata_ff;
    logic [3:0]       wstrb_ff;
    logic             do_write;
    logic [31:0]      merged;
    logic [CNT_W-1:0] wr_period;
    logic             rise;
    logic             fall;
    logic             expired;

    mmft_tick #(
        .DIV (TICK_DIV)
    ) u_tick (
        .ref_clk (ref_clk),
        .rst     (rst),
        .tick    (tick)
    );

    // three-stage input synchroniser, change counted when stages 2 and 3 agree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            in_sync_ff <= 3'h0;
            in_ff      <= 1'b0;
            in_prev_ff <= 1'b0;
        end else begin
            in_sync_ff <= {in_sync_ff[1:0], trig_in};
            if (in_sync_ff[1] == in_sync_ff[2]) begin
                in_ff <= in_sync_ff[2];
            end
            in_prev_ff <= in_ff;
        end
    end

    assign rise    = in_ff & ~in_prev_ff;
    assign fall    = ~in_ff & in_prev_ff;
    assign expired = (elapsed_ff >= period_ff);

    // axi write channels, address and data taken in either order
    // ready is a registered one-cycle pulse; payload captured as it rises
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_held_ff    <= 1'b0;
            w_held_ff     <= 1'b0;
            awaddr_ff     <= 8'h0;
            wdata_ff      <= 32'h0;
            wstrb_ff      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !s_axi_awready && !aw_held_ff && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                aw_held_ff    <= 1'b1;
                awaddr_ff     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !s_axi_wready && !w_held_ff && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
                w_held_ff    <= 1'b1;
                wdata_ff     <= s_axi_wdata;
                wstrb_ff     <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
            end
        end
    end

    assign do_write = aw_held_ff & w_held_ff & ~s_axi_bvalid;

    // byte-lane merge of write data onto the period register
    always_comb begin
        merged = {7'h0, period_ff};
        for (int i = 0; i < 4; i++) begin
            if (wstrb_ff[i]) begin
                merged[i*8 +: 8] = wdata_ff[i*8 +: 8];
            end
        end
        if (merged[31:CNT_W] != 7'h0 || merged[CNT_W-1:0] > PERIOD_MAX) begin
            wr_period = PERIOD_MAX;
        end else if (merged[CNT_W-1:0] < PERIOD_MIN) begin
            wr_period = PERIOD_MIN;
        end else begin
            wr_period = merged[CNT_W-1:0];
        end
    end

    assign period_wr = do_write && (awaddr_ff[7:2] == ADDR_PERIOD[7:2]);

    // write response and configuration registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            type_ff      <= MMFT_OFF;
            period_ff    <= PERIOD_RST;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OKAY;
                unique case (awaddr_ff[7:2])
                    ADDR_CTRL[7:2]: begin
                        if (wstrb_ff[0] && wdata_ff[2:0] <= 3'h4) begin
                            type_ff <= mmft_type_t'(wdata_ff[2:0]);
                        end
                    end
                    ADDR_PERIOD[7:2]: begin
                        period_ff <= wr_period;
                    end
                    ADDR_ELAPSED[7:2], ADDR_STATUS[7:2]: begin
                    end
                    default: begin
                        s_axi_bresp <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // axi read channel, one-cycle answer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                unique case (s_axi_araddr[7:2])
                    ADDR_CTRL[7:2]:    s_axi_rdata <= {29'h0, type_ff};
                    ADDR_PERIOD[7:2]:  s_axi_rdata <= {7'h0, period_ff};
                    ADDR_ELAPSED[7:2]: s_axi_rdata <= {7'h0, elapsed_ff};
                    ADDR_STATUS[7:2]: begin
                        s_axi_rdata <= {29'h0, in_ff, triggered, timer_out};
                    end
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // per-type timing behaviour
    always_comb begin
        nxt_elapsed   = elapsed_ff;
        nxt_running   = running_ff;
        nxt_out       = 1'b0;
        nxt_trig      = 1'b0;
        nxt_shot_flag = shot_flag_ff;
        unique case (type_ff)
            MMFT_OFF: begin
                nxt_elapsed   = '0;
                nxt_running   = 1'b0;
                nxt_shot_flag = 1'b0;
            end
            MMFT_PULSE: begin
                if (rise) begin
                    nxt_elapsed = '0;
                    nxt_running = 1'b1;
                end else if (running_ff && tick) begin
                    nxt_elapsed = elapsed_ff + 1'b1;
                    if (elapsed_ff + 1'b1 >= period_ff) begin
                        nxt_running = 1'b0;
                    end
                end
                nxt_out  = nxt_running;
                nxt_trig = nxt_running;
            end
            MMFT_ON_DELAY: begin
                nxt_running = 1'b0;
                if (!in_ff || fall) begin
                    nxt_elapsed = '0;
                end else if (tick && !expired) begin
                    nxt_elapsed = elapsed_ff + 1'b1;
                end
                nxt_out  = in_ff && (nxt_elapsed >= period_ff);
                nxt_trig = in_ff;
            end
            MMFT_ONE_SHOT: begin
                if (period_wr) begin
                    nxt_elapsed   = '0;
                    nxt_running   = 1'b1;
                    nxt_shot_flag = 1'b1;
                end else if (running_ff && in_ff && tick) begin
                    nxt_elapsed = elapsed_ff + 1'b1;
                    if (elapsed_ff + 1'b1 >= period_ff) begin
                        nxt_running = 1'b0;
                    end
                end
                if (running_ff && fall) begin
                    nxt_running = 1'b0;
                end
                nxt_out = nxt_running && in_ff;
                if (!nxt_out && timer_out && !period_wr) begin
                    nxt_shot_flag = 1'b0;
                end
                nxt_trig = nxt_shot_flag;
            end
            MMFT_MIN_ON: begin
                nxt_running = 1'b0;
                if (in_ff) begin
                    nxt_elapsed = '0;
                end else if (fall) begin
                    nxt_elapsed = {{(CNT_W-1){1'b0}}, 1'b1};
                end else if (elapsed_ff != '0 && tick) begin
                    if (elapsed_ff >= period_ff) begin
                        nxt_elapsed = '0;
                    end else begin
                        nxt_elapsed = elapsed_ff + 1'b1;
                    end
                end
                nxt_out  = in_ff || (nxt_elapsed != '0);
                nxt_trig = (nxt_elapsed != '0);
            end
            default: begin
                nxt_elapsed = '0;
                nxt_running = 1'b0;
            end
        endcase
    end

    // timer state and registered outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            elapsed_ff   <= '0;
            running_ff   <= 1'b0;
            shot_flag_ff <= 1'b0;
            timer_out    <= 1'b0;
            triggered    <= 1'b0;
        end else begin
            elapsed_ff   <= nxt_elapsed;
            running_ff   <= nxt_running;
            shot_flag_ff <= nxt_shot_flag;
            timer_out    <= nxt_out;
            triggered    <= nxt_trig;
        end
    end
endmodule

// File: test/mmft_checker.sv
// port assertions for the function timer
`timescale 1ns/1ps
module mmft_checker
    import mmft_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        trig_in,
    input wire logic        timer_out,
    input wire logic        triggered,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    mmft_type_t  mode_ff;
    logic [2:0]  age_ff;
    logic [6:0]  hist_ff;
    logic        wr_go;
    logic        hi_s;
    logic        lo_s;
    // both write channels taken at one edge, settled input levels
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign hi_s  = (&hist_ff) && trig_in;
    assign lo_s  = !(|hist_ff) && !trig_in;
    // mirror of the timer type and cycles since it changed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_ff <= MMFT_OFF;
            age_ff  <= 3'h0;
        end else if (wr_go && s_axi_awaddr == ADDR_CTRL && s_axi_wdata < 32'h5) begin
            mode_ff <= mmft_type_t'(s_axi_wdata[2:0]);
            age_ff  <= 3'h0;
        end else if (age_ff != 3'h7) begin
            age_ff <= age_ff + 3'h1;
        end
    end
    // trigger history, long enough to cover the input synchroniser
    always @(posedge ref_clk) begin
        hist_ff <= {hist_ff[5:0], trig_in};
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    off_idle_a: assert property ((age_ff == 3'h7 && mode_ff == MMFT_OFF) |-> !timer_out)
        else $error("output on in off type");
    pulse_start_a: assert property ((age_ff == 3'h7 && mode_ff == MMFT_PULSE && $rose(trig_in))
        |-> ##[1:8] timer_out)
        else $error("pulse did not start");
    pulse_flag_a: assert property ((age_ff == 3'h7 && mode_ff == MMFT_PULSE)
        |-> triggered == timer_out)
        else $error("pulse flag differs from output");
    delay_wait_a: assert property ((age_ff == 3'h7 && mode_ff == MMFT_ON_DELAY && lo_s)
        |-> !timer_out)
        else $error("delay output on with input off");
    delay_flag_a: assert property ((age_ff == 3'h7 && mode_ff == MMFT_ON_DELAY && (hi_s || lo_s))
        |-> triggered == trig_in)
        else $error("delay flag differs from input");
    shot_off_a: assert property ((age_ff == 3'h7 && mode_ff == MMFT_ONE_SHOT && lo_s)
        |-> !timer_out)
        else $error("shot output on with input off");
    minon_hold_a: assert property ((age_ff == 3'h7 && mode_ff == MMFT_MIN_ON && hi_s)
        |-> timer_out)
        else $error("min-on output off with input on");
    wr_resp_a: assert property (wr_go |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    rd_hold_a: assert property ((s_axi_rvalid && !s_axi_rready)
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
endmodule

// File: test/mmft_trig_model.sv
// wired control logic driving the trigger input
`timescale 1ns/1ps
module mmft_trig_model (
    input  wire logic ref_clk,
    input  wire logic level_req,
    output logic      trig_in
);
    // the level moves only just after a clock edge
    initial trig_in = 1'b0;
    always @(posedge ref_clk) begin
        trig_in <= level_req;
    end
endmodule

// File: test/mmft_top_tb.sv
// self-checking bench for the function timer
`timescale 1ns/1ps
module mmft_top_tb;
    import mmft_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        trig_req = 1'b0;
    logic        trig_in;
    logic        timer_out;
    logic        triggered;
    logic [7:0]  awaddr  = 8'h0;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata   = 32'h0;
    logic        wvalid  = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready  = 1'b0;
    logic [7:0]  araddr  = 8'h0;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready  = 1'b0;
    logic [31:0] rd_data;
    logic [1:0]  rd_resp;
    logic [1:0]  wr_resp;
    int          failures = 0;
    int          total_checks = 0;
    int          cyc = 0;
    always #5 ref_clk = ~ref_clk;
    mmft_trig_model trig_u (.ref_clk(ref_clk), .level_req(trig_req), .trig_in(trig_in));
    mmft_top #(.TICK_DIV(10)) dut_u (.ref_clk(ref_clk), .rst(rst), .trig_in(trig_in),
        .timer_out(timer_out), .triggered(triggered), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task automatic final_report();
        if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // n edges, then sample at the falling edge
    task automatic clk_wait(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic set_trig(input logic v);
        @(posedge ref_clk);
        trig_req <= v;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        logic b;
        aw = 1'b0;
        w  = 1'b0;
        b  = 1'b0;
        @(posedge ref_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!b) begin
            @(negedge ref_clk);
            aw = aw || awready;
            w  = w || wready;
            b  = bvalid;
            wr_resp = bresp;
            @(posedge ref_clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic got;
        got = 1'b0;
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!got) begin
            @(negedge ref_clk);
            got = rvalid;
            rd_data = rdata;
            rd_resp = rresp;
            @(posedge ref_clk);
        end
        arvalid <= 1'b0;
        rready  <= 1'b0;
    endtask
    // hang guard, far above the expected run length
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            failures++;
            $display("Error at %0t: timeout", $time);
            final_report();
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        // reset values and an unmapped place
        axi_rd(ADDR_CTRL);
        chk(rd_data, 32'h0);
        axi_rd(ADDR_PERIOD);
        chk(rd_data, 32'h1);
        axi_rd(ADDR_ELAPSED);
        chk(rd_data, 32'h0);
        axi_rd(ADDR_STATUS);
        chk(rd_data, 32'h0);
        axi_rd(8'h10);
        chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
        chk(rd_data, 32'h0);
        // period limits clamp
        axi_wr(ADDR_PERIOD, 32'h0);
        axi_rd(ADDR_PERIOD);
        chk(rd_data, 32'h1);
        axi_wr(ADDR_PERIOD, 32'h1ffffff);
        axi_rd(ADDR_PERIOD);
        chk(rd_data, {7'h0, PERIOD_MAX});
        // ignored and refused writes still answer
        axi_wr(ADDR_ELAPSED, 32'h7);
        chk({30'h0, wr_resp}, {30'h0, RESP_OKAY});
        axi_rd(ADDR_ELAPSED);
        chk(rd_data, 32'h0);
        axi_wr(8'h10, 32'h1);
        chk({30'h0, wr_resp}, {30'h0, RESP_SLVERR});
        // every type, then an illegal code that must be ignored
        for (int t = 0; t < 6; t++) begin
            axi_wr(ADDR_CTRL, 32'(t));
            axi_rd(ADDR_CTRL);
            chk(rd_data, (t < 5) ? 32'(t) : 32'h4);
        end
        // pulse with a re-trigger
        axi_wr(ADDR_CTRL, 32'h1);
        axi_wr(ADDR_PERIOD, 32'h5);
        set_trig(1'b1);
        clk_wait(20);
        chk({31'h0, timer_out}, 32'h1);
        axi_rd(ADDR_ELAPSED);
        chk({31'h0, rd_data != 32'h0}, 32'h1);
        axi_rd(ADDR_STATUS);
        chk({31'h0, rd_data[ST_OUT_BIT]}, 32'h1);
        set_trig(1'b0);
        clk_wait(3);
        set_trig(1'b1);
        clk_wait(35);
        chk({31'h0, timer_out}, 32'h1);
        set_trig(1'b0);
        clk_wait(100);
        chk({31'h0, timer_out}, 32'h0);
        // on-delay
        axi_wr(ADDR_CTRL, 32'h2);
        set_trig(1'b1);
        clk_wait(25);
        chk({31'h0, timer_out}, 32'h0);
        clk_wait(50);
        chk({31'h0, timer_out}, 32'h1);
        set_trig(1'b0);
        clk_wait(10);
        chk({31'h0, timer_out}, 32'h0);
        axi_rd(ADDR_ELAPSED);
        chk(rd_data, 32'h0);
        // min-on with an early return of the input
        axi_wr(ADDR_CTRL, 32'h4);
        set_trig(1'b1);
        clk_wait(10);
        set_trig(1'b0);
        clk_wait(20);
        chk({31'h0, timer_out}, 32'h1);
        chk({31'h0, triggered}, 32'h1);
        set_trig(1'b1);
        clk_wait(5);
        set_trig(1'b0);
        clk_wait(35);
        chk({31'h0, timer_out}, 32'h1);
        clk_wait(60);
        chk({31'h0, timer_out}, 32'h0);
        chk({31'h0, triggered}, 32'h0);
        // one-shot armed with the input off, then shot and re-shot
        axi_wr(ADDR_CTRL, 32'h3);
        axi_wr(ADDR_PERIOD, 32'h5);
        clk_wait(20);
        chk({31'h0, timer_out}, 32'h0);
        set_trig(1'b1);
        clk_wait(10);
        chk({31'h0, timer_out}, 32'h1);
        chk({31'h0, triggered}, 32'h1);
        clk_wait(80);
        chk({31'h0, triggered}, 32'h0);
        clk_wait(60);
        chk({31'h0, timer_out}, 32'h0);
        axi_wr(ADDR_PERIOD, 32'h5);
        clk_wait(8);
        chk({31'h0, timer_out}, 32'h1);
        set_trig(1'b0);
        clk_wait(8);
        chk({31'h0, timer_out}, 32'h0);
        final_report();
    end
endmodule
bind mmft_top mmft_checker chk_u (.ref_clk(ref_clk), .rst(rst), .trig_in(trig_in),
    .timer_out(timer_out), .triggered(triggered), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
